// ---- cab_pkg.sv ----
// Contract
// [RL1] byte add/sub: write, six flags, one cycle
// [RL2] word add/sub: no half-carry, two cycles
// [RL3] and/or/xor: Z,N,V,S only, one cycle
// [RL4] mask clear/set with constant, Z,N,V,S
// [RL5] self check: no change, Z,N,V,S
// [RL6] three products into R1:R0, Z,C, two cycles
// [RL7] fractional products shifted left one bit
// [RL8] relative jump/call: PC plus offset plus one
// [RL9] indirect: PC low from pointer, high zeroed
// [RL10] equal compare skips two or three words; the code skips one or two words, moving PC by 2 or 3
// [RL11] compares only set six flags
// [RL12] register bit skips on clear or set
// [RL13] I/O bit skips on clear or set
// [RL14] generic flag branch, one or two cycles
// [RL15] signed branches test N xor V
// [RL16] unsigned branches test carry; Z, N branches
// [RL17] interrupt-state branches test I flag
// [RL18] half-carry, T, overflow dedicated branches
// [RL19] two-word skipped instruction costs extra word
// [RL20] sign flag is N xor V
//
// package of constants and types for the execution unit
// assumes a decoder that drives one operation per issue strobe

package cab_pkg;

	// ****************
	// widths
	// ****************
	localparam int PC_W = 22;
	localparam int OFS_W = 12;
	localparam int REG_AW = 8;

	// ****************
	// status flag positions
	// ****************
	localparam int SB_C = 0;
	localparam int SB_Z = 1;
	localparam int SB_N = 2;
	localparam int SB_V = 3;
	localparam int SB_S = 4;
	localparam int SB_H = 5;
	localparam int SB_T = 6;
	localparam int SB_I = 7;

	// flag update masks per operation class
	localparam logic [7:0] MASK_ARITH = 8'h3f;
	localparam logic [7:0] MASK_WORD = 8'h1f;
	localparam logic [7:0] MASK_LOGIC = 8'h1e;
	localparam logic [7:0] MASK_MUL = 8'h03;

	// ****************
	// reset values
	// ****************
	localparam logic [7:0] SREG_RST = 8'h00;
	localparam logic [PC_W-1:0] PC_RST = 22'h00_0000;

	// ****************
	// cycle counts and program-counter steps
	// ****************
	localparam logic [1:0] CYC_BYTE_OP = 2'h1;
	localparam logic [1:0] CYC_WORD_OP = 2'h2;
	localparam logic [1:0] CYC_MUL_OP = 2'h2;
	localparam logic [1:0] CYC_JUMP = 2'h2;
	localparam logic [1:0] CYC_CALL = 2'h2;
	localparam logic [1:0] CYC_SKIP_ONE = 2'h2;
	localparam logic [1:0] CYC_SKIP_TWO = 2'h3;
	localparam logic [1:0] CYC_BR_TAKEN = 2'h2;
	localparam logic [PC_W-1:0] STEP_NEXT = 22'h00_0001;
	localparam logic [PC_W-1:0] STEP_SKIP_ONE = 22'h00_0002;
	localparam logic [PC_W-1:0] STEP_SKIP_TWO = 22'h00_0003;

	// ****************
	// register offsets
	// ****************
	localparam logic [REG_AW-1:0] OFS_STATUS = 8'h00;
	localparam logic [REG_AW-1:0] OFS_PC = 8'h04;
	localparam logic [REG_AW-1:0] OFS_RESULT = 8'h08;

	// ****************
	// operations and states
	// ****************
	typedef enum logic [5:0] {
		OP_NONE, OP_SUM, OP_SUM_CARRY, OP_DIFF, OP_DIFFERENCE_BORROW_IN,
		OP_AND, OP_OR, OP_BITWISE_XOR, OP_CLEAR_MASK_BITS, OP_SET_MASK_BITS,
		OP_SELF_FLAG_CHECK, OP_WORD_IMMEDIATE_SUM, OP_WORD_IMMEDIATE_DIFFERENCE,
		OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT, OP_MIXED_SIGN_PRODUCT,
		OP_FRACTIONAL_UNSIGNED_PRODUCT, OP_FRACTIONAL_SIGNED_PRODUCT,
		OP_FRACTIONAL_MIXED_PRODUCT, OP_RELATIVE_JUMP, OP_RELATIVE_SUBROUTINE_CALL,
		OP_INDIRECT_JUMP, OP_INDIRECT_SUBROUTINE_CALL, OP_EQUAL_SKIP_COMPARE,
		OP_COMPARE, OP_COMPARE_CARRY, OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET,
		OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET, OP_BRANCH_FLAG_SET,
		OP_BRANCH_FLAG_CLEAR, OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT,
		OP_BRANCH_SAME_HIGHER, OP_BRANCH_LOWER, OP_BRANCH_EQUAL, OP_BRANCH_NOT_EQUAL,
		OP_BRANCH_MINUS, OP_BRANCH_PLUS, OP_BRANCH_IRQ_ENABLED,
		OP_BRANCH_IRQ_DISABLED, OP_BRANCH_HALF_CARRY_SET, OP_BRANCH_HALF_CARRY_CLEAR,
		OP_BRANCH_TRANSFER_BIT_SET, OP_BRANCH_TRANSFER_BIT_CLEAR,
		OP_BRANCH_OVERFLOW_SET, OP_BRANCH_OVERFLOW_CLEAR
	} cab_op_t;

	typedef enum logic {ST_IDLE, ST_WAIT} cab_state_t;

endpackage

// ---- cab_ex_if.sv ----
// interface between the execution core and its product and branch-test units
// assumes the core drives operands and reads results in the same cycle

`timescale 1ns/100ps

interface cab_ex_if;
	logic [7:0] mul_a;
	logic [7:0] mul_b;
	logic mul_a_signed;
	logic mul_b_signed;
	logic mul_frac;
	logic [15:0] mul_res;
	logic mul_z;
	logic mul_c;
	cab_pkg::cab_op_t cond_op;
	logic [7:0] cond_sreg;
	logic [2:0] cond_sel;
	logic cond_is_branch;
	logic cond_taken;

	modport core (
		output mul_a, mul_b, mul_a_signed, mul_b_signed, mul_frac,
		input mul_res, mul_z, mul_c,
		output cond_op, cond_sreg, cond_sel,
		input cond_is_branch, cond_taken
	);
	modport mul_mp (
		input mul_a, mul_b, mul_a_signed, mul_b_signed, mul_frac,
		output mul_res, mul_z, mul_c
	);
	modport cond_mp (
		input cond_op, cond_sreg, cond_sel,
		output cond_is_branch, cond_taken
	);
endinterface

// ---- cab_mul.sv ----
// combinational 8x8 multiplier with signed, mixed and fractional forms
// assumes the core registers the product over its two-cycle slot

`timescale 1ns/100ps

module cab_mul (
	cab_ex_if.mul_mp ex // operands in, product out
);
	logic signed [8:0] op_a;
	logic signed [8:0] op_b;
	logic signed [17:0] prod;
	logic [15:0] raw;

	// sign-extend each operand only when it is treated as signed
	assign op_a = {ex.mul_a_signed & ex.mul_a[7], ex.mul_a};
	assign op_b = {ex.mul_b_signed & ex.mul_b[7], ex.mul_b};
	assign prod = op_a * op_b; // [RL6]
	assign raw = prod[15:0];

	// fractional forms shift left one place, carry is the top raw bit
	assign ex.mul_res = ex.mul_frac ? {raw[14:0], 1'b0} : raw; // [RL7]
	assign ex.mul_c = raw[15]; // [RL6]
	assign ex.mul_z = (ex.mul_res == 16'h0000);
endmodule

// ---- cab_cond.sv ----
// branch condition test on the status flags
// assumes the status byte is the one valid when the branch issues

`timescale 1ns/100ps

module cab_cond (
	cab_ex_if.cond_mp ex // operation and flags in, decision out
);
	logic [2:0] sel;
	logic want;
	logic signed_test;
	logic nv;

	assign nv = ex.cond_sreg[cab_pkg::SB_N] ^ ex.cond_sreg[cab_pkg::SB_V]; // [RL15]

	// map each branch to a flag index and a wanted level
	always_comb
	begin
		sel = ex.cond_sel;
		want = 1'b1;
		signed_test = 1'b0;
		ex.cond_is_branch = 1'b1;
		case (ex.cond_op)
			cab_pkg::OP_BRANCH_FLAG_SET: want = 1'b1; // [RL14]
			cab_pkg::OP_BRANCH_FLAG_CLEAR: want = 1'b0; // [RL14]
			cab_pkg::OP_BRANCH_SIGNED_GE:
			begin
				signed_test = 1'b1;
				want = 1'b0; // [RL15]
			end
			cab_pkg::OP_BRANCH_SIGNED_LT: signed_test = 1'b1; // [RL15]
			cab_pkg::OP_BRANCH_SAME_HIGHER:
			begin
				sel = 3'(cab_pkg::SB_C);
				want = 1'b0; // [RL16]
			end
			cab_pkg::OP_BRANCH_LOWER: sel = 3'(cab_pkg::SB_C); // [RL16]
			cab_pkg::OP_BRANCH_EQUAL: sel = 3'(cab_pkg::SB_Z); // [RL16]
			cab_pkg::OP_BRANCH_NOT_EQUAL:
			begin
				sel = 3'(cab_pkg::SB_Z);
				want = 1'b0;
			end
			cab_pkg::OP_BRANCH_MINUS: sel = 3'(cab_pkg::SB_N); // [RL16]
			cab_pkg::OP_BRANCH_PLUS:
			begin
				sel = 3'(cab_pkg::SB_N);
				want = 1'b0;
			end
			cab_pkg::OP_BRANCH_IRQ_ENABLED: sel = 3'(cab_pkg::SB_I); // [RL17]
			cab_pkg::OP_BRANCH_IRQ_DISABLED:
			begin
				sel = 3'(cab_pkg::SB_I);
				want = 1'b0; // [RL17]
			end
			cab_pkg::OP_BRANCH_HALF_CARRY_SET: sel = 3'(cab_pkg::SB_H); // [RL18]
			cab_pkg::OP_BRANCH_HALF_CARRY_CLEAR:
			begin
				sel = 3'(cab_pkg::SB_H);
				want = 1'b0; // [RL18]
			end
			cab_pkg::OP_BRANCH_TRANSFER_BIT_SET: sel = 3'(cab_pkg::SB_T); // [RL18]
			cab_pkg::OP_BRANCH_TRANSFER_BIT_CLEAR:
			begin
				sel = 3'(cab_pkg::SB_T);
				want = 1'b0; // [RL18]
			end
			cab_pkg::OP_BRANCH_OVERFLOW_SET: sel = 3'(cab_pkg::SB_V); // [RL18]
			cab_pkg::OP_BRANCH_OVERFLOW_CLEAR:
			begin
				sel = 3'(cab_pkg::SB_V);
				want = 1'b0; // [RL18]
			end
			default: ex.cond_is_branch = 1'b0;
		endcase
	end

	assign ex.cond_taken = ex.cond_is_branch &
		((signed_test ? nv : ex.cond_sreg[sel]) == want);
endmodule

// ---- cab_alu_branch_unit.sv ----
// execution unit: byte and word arithmetic, logic, products, compares,
// skips, jumps and conditional branches, with status flags and PC
// assumes the decoder issues one operation while busy is low and puts
// immediate constants on the r operand for the byte forms

`timescale 1ns/100ps

module cab_alu_branch_unit #(
	parameter logic [1:0] CALL_CYCLES = cab_pkg::CYC_CALL // relative or indirect call
) (
	input wire logic clk_in, // core clock
	input wire logic rstn_in, // async reset, active low
	input wire logic issue_in, // operation strobe
	input wire cab_pkg::cab_op_t op_in, // operation
	input wire logic [7:0] opd_d_in, // destination operand
	input wire logic [7:0] opd_r_in, // source operand or constant
	input wire logic [7:0] imm_in, // word constant, bit or flag select
	input wire logic [15:0] pair_in, // register pair or pointer
	input wire logic [11:0] offset_in, // signed relative offset
	input wire logic [7:0] io_val_in, // addressed I/O byte
	input wire logic next_two_word_in, // following instruction is two words
	input wire logic [7:0] reg_addr_in, // register address
	input wire logic [31:0] reg_wdata_in, // register write data
	input wire logic reg_wr_in, // register write strobe
	input wire logic reg_rd_in, // register read strobe
	output logic [31:0] reg_rdata_out, // register read data
	output logic busy_out, // multi-cycle operation in progress
	output logic done_out, // operation completes
	output logic wr_en_out, // result write
	output logic wr_pair_out, // write is a register pair
	output logic wr_r1r0_out, // pair target is R1:R0
	output logic [15:0] result_out, // result value
	output logic [cab_pkg::PC_W-1:0] pc_out, // program counter
	output logic [7:0] sreg_out // status flags
);

	// ****************
	// functions
	// ****************

	// byte add or subtract with carry/borrow in, returns {v,h,c,result}
	function automatic logic [10:0] add8(
		input logic [7:0] a,
		input logic [7:0] b,
		input logic cin,
		input logic sub
	);
		logic [7:0] bx;
		logic cx;
		logic [8:0] s;
		logic [4:0] hs;
		bx = sub ? ~b : b;
		cx = sub ? ~cin : cin;
		s = {1'b0, a} + {1'b0, bx} + {8'h00, cx};
		hs = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cx};
		add8 = {(a[7] == bx[7]) & (s[7] != a[7]), hs[4] ^ sub, s[8] ^ sub, s[7:0]};
	endfunction

	// place flag values at their positions, sign from N and V
	function automatic logic [7:0] pack_flags(
		input logic h,
		input logic v,
		input logic n,
		input logic z,
		input logic c
	);
		logic [7:0] f;
		f = 8'h00;
		f[cab_pkg::SB_H] = h;
		f[cab_pkg::SB_V] = v;
		f[cab_pkg::SB_N] = n;
		f[cab_pkg::SB_Z] = z;
		f[cab_pkg::SB_C] = c;
		f[cab_pkg::SB_S] = n ^ v; // [RL20]
		pack_flags = f;
	endfunction

	// program counter plus sign-extended offset plus one
	function automatic logic [cab_pkg::PC_W-1:0] pc_rel(
		input logic [cab_pkg::PC_W-1:0] pc,
		input logic [11:0] off
	);
		pc_rel = pc + {{(cab_pkg::PC_W - cab_pkg::OFS_W){off[11]}}, off}
			+ cab_pkg::STEP_NEXT;
	endfunction

	// ****************
	// state
	// ****************
	cab_pkg::cab_state_t state;
	logic [1:0] cnt;
	logic [7:0] sreg;
	logic [cab_pkg::PC_W-1:0] pc;
	logic [15:0] last_res;
	logic [15:0] pend_res;
	logic pend_wr;
	logic pend_pair;
	logic pend_r1r0;
	logic [7:0] pend_mask;
	logic [7:0] pend_flags;
	logic [cab_pkg::PC_W-1:0] pend_pc;

	// ****************
	// sub-units
	// ****************
	cab_ex_if ex ();

	cab_mul u_mul (
		.ex(ex.mul_mp)
	);

	cab_cond u_cond (
		.ex(ex.cond_mp)
	);

	// multiplier operand signedness
	assign ex.mul_a = opd_d_in;
	assign ex.mul_b = opd_r_in;
	assign ex.mul_a_signed = (op_in == cab_pkg::OP_SIGNED_PRODUCT) |
		(op_in == cab_pkg::OP_MIXED_SIGN_PRODUCT) |
		(op_in == cab_pkg::OP_FRACTIONAL_SIGNED_PRODUCT) |
		(op_in == cab_pkg::OP_FRACTIONAL_MIXED_PRODUCT); // [RL6]
	assign ex.mul_b_signed = (op_in == cab_pkg::OP_SIGNED_PRODUCT) |
		(op_in == cab_pkg::OP_FRACTIONAL_SIGNED_PRODUCT);
	assign ex.mul_frac = (op_in == cab_pkg::OP_FRACTIONAL_UNSIGNED_PRODUCT) |
		(op_in == cab_pkg::OP_FRACTIONAL_SIGNED_PRODUCT) |
		(op_in == cab_pkg::OP_FRACTIONAL_MIXED_PRODUCT); // [RL7]

	// branch test inputs
	assign ex.cond_op = op_in;
	assign ex.cond_sreg = sreg;
	assign ex.cond_sel = imm_in[2:0];

	// ****************
	// byte arithmetic and logic
	// ****************
	logic is_sub;
	logic with_carry;
	logic keep_z;
	logic [10:0] ar;
	logic ar_z;
	logic [7:0] lr;

	// subtract forms, carry-in forms and zero-chaining forms
	assign is_sub = (op_in == cab_pkg::OP_DIFF) |
		(op_in == cab_pkg::OP_DIFFERENCE_BORROW_IN) |
		(op_in == cab_pkg::OP_COMPARE) | (op_in == cab_pkg::OP_COMPARE_CARRY);
	assign with_carry = (op_in == cab_pkg::OP_SUM_CARRY) |
		(op_in == cab_pkg::OP_DIFFERENCE_BORROW_IN) |
		(op_in == cab_pkg::OP_COMPARE_CARRY);
	assign keep_z = with_carry & is_sub;
	assign ar = add8(opd_d_in, opd_r_in, with_carry & sreg[cab_pkg::SB_C], is_sub); // [RL1]
	assign ar_z = (ar[7:0] == 8'h00) & (~keep_z | sreg[cab_pkg::SB_Z]);

	// logic result per operation
	assign lr = (op_in == cab_pkg::OP_AND) ? (opd_d_in & opd_r_in) : // [RL3]
		(op_in == cab_pkg::OP_OR) ? (opd_d_in | opd_r_in) :
		(op_in == cab_pkg::OP_BITWISE_XOR) ? (opd_d_in ^ opd_r_in) :
		(op_in == cab_pkg::OP_CLEAR_MASK_BITS) ? (opd_d_in & ~opd_r_in) : // [RL4]
		(op_in == cab_pkg::OP_SET_MASK_BITS) ? (opd_d_in | opd_r_in) : // [RL4]
		(opd_d_in & opd_d_in); // [RL5]

	// ****************
	// word arithmetic
	// ****************
	logic w_sub;
	logic [15:0] wk;
	logic [16:0] ws;
	logic w_v;

	// pair plus or minus a six-bit constant
	assign w_sub = (op_in == cab_pkg::OP_WORD_IMMEDIATE_DIFFERENCE);
	assign wk = w_sub ? ~{10'h000, imm_in[5:0]} : {10'h000, imm_in[5:0]};
	assign ws = {1'b0, pair_in} + {1'b0, wk} + {16'h0000, w_sub}; // [RL2]
	assign w_v = (pair_in[15] == wk[15]) & (ws[15] != pair_in[15]);

	// ****************
	// skips and jumps
	// ****************
	logic skip_go;
	logic [cab_pkg::PC_W-1:0] pc_next;
	logic [cab_pkg::PC_W-1:0] pc_skip;
	logic [1:0] cyc_skip;

	// skip conditions
	assign skip_go =
		((op_in == cab_pkg::OP_EQUAL_SKIP_COMPARE) & (opd_d_in == opd_r_in)) | // [RL10]
		((op_in == cab_pkg::OP_SKIP_REG_BIT_CLEAR) & ~opd_r_in[imm_in[2:0]]) | // [RL12]
		((op_in == cab_pkg::OP_SKIP_REG_BIT_SET) & opd_r_in[imm_in[2:0]]) | // [RL12]
		((op_in == cab_pkg::OP_SKIP_IO_BIT_CLEAR) & ~io_val_in[imm_in[2:0]]) | // [RL13]
		((op_in == cab_pkg::OP_SKIP_IO_BIT_SET) & io_val_in[imm_in[2:0]]); // [RL13]

	// skipping a two-word instruction moves one word further
	assign pc_next = pc + cab_pkg::STEP_NEXT;
	assign pc_skip = pc + (next_two_word_in ? cab_pkg::STEP_SKIP_TWO
		: cab_pkg::STEP_SKIP_ONE); // [RL19]
	assign cyc_skip = next_two_word_in ? cab_pkg::CYC_SKIP_TWO
		: cab_pkg::CYC_SKIP_ONE; // [RL19]

	// ****************
	// per-operation outcome
	// ****************
	logic [15:0] nx_res;
	logic nx_wr;
	logic nx_pair;
	logic nx_r1r0;
	logic [7:0] nx_mask;
	logic [7:0] nx_flags;
	logic [cab_pkg::PC_W-1:0] nx_pc;
	logic [1:0] nx_cyc;

	always_comb
	begin
		nx_res = 16'h0000;
		nx_wr = 1'b0;
		nx_pair = 1'b0;
		nx_r1r0 = 1'b0;
		nx_mask = 8'h00;
		nx_flags = 8'h00;
		nx_pc = pc_next;
		nx_cyc = cab_pkg::CYC_BYTE_OP;
		case (op_in)
			cab_pkg::OP_SUM, cab_pkg::OP_SUM_CARRY,
			cab_pkg::OP_DIFF, cab_pkg::OP_DIFFERENCE_BORROW_IN:
			begin
				nx_res = {8'h00, ar[7:0]};
				nx_wr = 1'b1;
				nx_mask = cab_pkg::MASK_ARITH;
				nx_flags = pack_flags(ar[9], ar[10], ar[7], ar_z, ar[8]); // [RL1]
			end
			cab_pkg::OP_COMPARE, cab_pkg::OP_COMPARE_CARRY:
			begin
				nx_mask = cab_pkg::MASK_ARITH;
				nx_flags = pack_flags(ar[9], ar[10], ar[7], ar_z, ar[8]); // [RL11]
			end
			cab_pkg::OP_AND, cab_pkg::OP_OR, cab_pkg::OP_BITWISE_XOR,
			cab_pkg::OP_CLEAR_MASK_BITS, cab_pkg::OP_SET_MASK_BITS:
			begin
				nx_res = {8'h00, lr};
				nx_wr = 1'b1;
				nx_mask = cab_pkg::MASK_LOGIC; // [RL3]
				nx_flags = pack_flags(1'b0, 1'b0, lr[7], lr == 8'h00, 1'b0);
			end
			cab_pkg::OP_SELF_FLAG_CHECK:
			begin
				nx_mask = cab_pkg::MASK_LOGIC; // [RL5]
				nx_flags = pack_flags(1'b0, 1'b0, lr[7], lr == 8'h00, 1'b0);
			end
			cab_pkg::OP_WORD_IMMEDIATE_SUM, cab_pkg::OP_WORD_IMMEDIATE_DIFFERENCE:
			begin
				nx_res = ws[15:0];
				nx_wr = 1'b1;
				nx_pair = 1'b1;
				nx_mask = cab_pkg::MASK_WORD; // [RL2]
				nx_flags = pack_flags(1'b0, w_v, ws[15], ws[15:0] == 16'h0000,
					ws[16] ^ w_sub);
				nx_cyc = cab_pkg::CYC_WORD_OP; // [RL2]
			end
			cab_pkg::OP_UNSIGNED_PRODUCT, cab_pkg::OP_SIGNED_PRODUCT,
			cab_pkg::OP_MIXED_SIGN_PRODUCT, cab_pkg::OP_FRACTIONAL_UNSIGNED_PRODUCT,
			cab_pkg::OP_FRACTIONAL_SIGNED_PRODUCT, cab_pkg::OP_FRACTIONAL_MIXED_PRODUCT:
			begin
				nx_res = ex.mul_res;
				nx_wr = 1'b1;
				nx_pair = 1'b1;
				nx_r1r0 = 1'b1; // [RL6]
				nx_mask = cab_pkg::MASK_MUL;
				nx_flags = pack_flags(1'b0, 1'b0, 1'b0, ex.mul_z, ex.mul_c);
				nx_cyc = cab_pkg::CYC_MUL_OP; // [RL6] [RL7]
			end
			cab_pkg::OP_RELATIVE_JUMP:
			begin
				nx_pc = pc_rel(pc, offset_in); // [RL8]
				nx_cyc = cab_pkg::CYC_JUMP;
			end
			cab_pkg::OP_RELATIVE_SUBROUTINE_CALL:
			begin
				nx_pc = pc_rel(pc, offset_in); // [RL8]
				nx_cyc = CALL_CYCLES;
			end
			cab_pkg::OP_INDIRECT_JUMP:
			begin
				nx_pc = {6'h00, pair_in}; // [RL9]
				nx_cyc = cab_pkg::CYC_JUMP;
			end
			cab_pkg::OP_INDIRECT_SUBROUTINE_CALL:
			begin
				nx_pc = {6'h00, pair_in}; // [RL9]
				nx_cyc = CALL_CYCLES;
			end
			cab_pkg::OP_EQUAL_SKIP_COMPARE, cab_pkg::OP_SKIP_REG_BIT_CLEAR,
			cab_pkg::OP_SKIP_REG_BIT_SET, cab_pkg::OP_SKIP_IO_BIT_CLEAR,
			cab_pkg::OP_SKIP_IO_BIT_SET:
			begin
				if (skip_go)
				begin
					nx_pc = pc_skip; // [RL10] [RL12] [RL13]
					nx_cyc = cyc_skip;
				end
			end
			default:
			begin
				if (ex.cond_taken)
				begin
					nx_pc = pc_rel(pc, offset_in); // [RL14]
					nx_cyc = cab_pkg::CYC_BR_TAKEN;
				end
			end
		endcase
	end

	// ****************
	// sequencing
	// ****************
	logic in_idle;
	logic take;
	logic commit;
	logic [15:0] c_res;
	logic c_wr;
	logic c_pair;
	logic c_r1r0;
	logic [7:0] c_mask;
	logic [7:0] c_flags;
	logic [cab_pkg::PC_W-1:0] c_pc;
	logic next_wait;

	// one-cycle operations commit at issue, others at their last cycle
	assign in_idle = (state == cab_pkg::ST_IDLE);
	assign take = in_idle & issue_in;
	assign commit = (take & (nx_cyc == cab_pkg::CYC_BYTE_OP)) |
		(~in_idle & (cnt == 2'h1));
	assign next_wait = (take & (nx_cyc != cab_pkg::CYC_BYTE_OP)) |
		(~in_idle & (cnt != 2'h1));

	// values to commit come straight from decode or from the pending copy
	assign c_res = in_idle ? nx_res : pend_res;
	assign c_wr = in_idle ? nx_wr : pend_wr;
	assign c_pair = in_idle ? nx_pair : pend_pair;
	assign c_r1r0 = in_idle ? nx_r1r0 : pend_r1r0;
	assign c_mask = in_idle ? nx_mask : pend_mask;
	assign c_flags = in_idle ? nx_flags : pend_flags;
	assign c_pc = in_idle ? nx_pc : pend_pc;

	// state and remaining-cycle count
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			state <= cab_pkg::ST_IDLE;
			cnt <= 2'h0;
		end
		else
		begin
			state <= next_wait ? cab_pkg::ST_WAIT : cab_pkg::ST_IDLE;
			cnt <= take ? nx_cyc - 2'h1 : (in_idle ? 2'h0 : cnt - 2'h1);
		end
	end

	// pending outcome of a multi-cycle operation
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			pend_res <= 16'h0000;
			{pend_wr, pend_pair, pend_r1r0} <= 3'h0;
			pend_mask <= 8'h00;
			pend_flags <= 8'h00;
			pend_pc <= cab_pkg::PC_RST;
		end
		else if (take)
		begin
			pend_res <= nx_res;
			{pend_wr, pend_pair, pend_r1r0} <= {nx_wr, nx_pair, nx_r1r0};
			pend_mask <= nx_mask;
			pend_flags <= nx_flags;
			pend_pc <= nx_pc;
		end
	end

	// flags and program counter; a commit wins over a software write
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			sreg <= cab_pkg::SREG_RST;
			pc <= cab_pkg::PC_RST;
			last_res <= 16'h0000;
		end
		else if (commit)
		begin
			sreg <= (sreg & ~c_mask) | (c_flags & c_mask); // [RL3] [RL11]
			pc <= c_pc;
			last_res <= c_wr ? c_res : last_res;
		end
		else if (reg_wr_in)
		begin
			sreg <= (reg_addr_in == cab_pkg::OFS_STATUS) ? reg_wdata_in[7:0] : sreg;
			pc <= (reg_addr_in == cab_pkg::OFS_PC) ? reg_wdata_in[cab_pkg::PC_W-1:0] : pc;
		end
	end

	// ****************
	// outputs and register reads
	// ****************
	logic [31:0] rd_mux;

	assign rd_mux = (reg_addr_in == cab_pkg::OFS_STATUS) ? {24'h00_0000, sreg} :
		(reg_addr_in == cab_pkg::OFS_PC) ? {10'h000, pc} :
		(reg_addr_in == cab_pkg::OFS_RESULT) ? {15'h0000, busy_out, last_res} :
		32'h0000_0000;

	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			reg_rdata_out <= 32'h0000_0000;
			{busy_out, done_out, wr_en_out, wr_pair_out, wr_r1r0_out} <= 5'h00;
			result_out <= 16'h0000;
		end
		else
		begin
			reg_rdata_out <= reg_rd_in ? rd_mux : 32'h0000_0000;
			busy_out <= next_wait;
			done_out <= commit;
			wr_en_out <= commit & c_wr;
			wr_pair_out <= commit & c_pair;
			wr_r1r0_out <= commit & c_r1r0;
			result_out <= commit ? c_res : result_out;
		end
	end

	// architectural state mirrored on the ports
	assign pc_out = pc;
	assign sreg_out = sreg;

endmodule

// ---- cab_alu_checker.sv ----
// checker: timing and flag relations seen at the unit ports
// assumes it is bound onto cab_alu_branch_unit
`timescale 1ns/100ps
module cab_alu_checker (
	input wire logic clk_in, // clock
	input wire logic rstn_in, // reset, active low
	input wire logic issue_in, // strobe
	input wire cab_pkg::cab_op_t op_in, // operation
	input wire logic [15:0] pair_in, // pointer
	input wire logic busy_out, // busy
	input wire logic done_out, // done
	input wire logic wr_en_out, // write
	input wire logic wr_r1r0_out, // to R1:R0
	input wire logic [cab_pkg::PC_W-1:0] pc_out, // pc
	input wire logic [7:0] sreg_out // flags
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	// accepted issue
	wire go = issue_in && !busy_out;
	sequence two_step;
		busy_out ##1 done_out;
	endsequence
	AST_BYTE_ONE: assert property (go && op_in == cab_pkg::OP_SUM |=> done_out && wr_en_out)
		else $error("byte sum not done in one cycle");
	AST_WORD_TWO: assert property (go && op_in == cab_pkg::OP_WORD_IMMEDIATE_SUM |=> two_step)
		else $error("word sum not two cycles");
	AST_PROD_PAIR: assert property (go && op_in == cab_pkg::OP_SIGNED_PRODUCT
		|=> two_step ##0 wr_r1r0_out) else $error("product timing or target wrong");
	AST_LOGIC_KEEP: assert property (go && op_in == cab_pkg::OP_OR
		|=> $stable({sreg_out[5], sreg_out[0]})) else $error("logic op changed C or H");
	AST_CMP_NOWR: assert property (go && op_in == cab_pkg::OP_COMPARE |=> done_out && !wr_en_out)
		else $error("compare wrote a result");
	AST_IND_PC: assert property (go && op_in == cab_pkg::OP_INDIRECT_JUMP
		|=> two_step ##0 pc_out == {6'h00, $past(pair_in, 2)}) else $error("indirect pc wrong");
	AST_SIGN_NV: assert property (go && op_in == cab_pkg::OP_DIFFERENCE_BORROW_IN
		|=> sreg_out[4] == (sreg_out[2] ^ sreg_out[3])) else $error("sign flag not N xor V");
	AST_BR_SPAN: assert property (go && op_in >= cab_pkg::OP_BRANCH_FLAG_SET |-> ##[1:2] done_out)
		else $error("branch not done in two cycles");
endmodule
bind cab_alu_branch_unit cab_alu_checker i_cab_alu_checker (.clk_in(clk_in), .rstn_in(rstn_in),
	.issue_in(issue_in), .op_in(op_in), .pair_in(pair_in), .busy_out(busy_out),
	.done_out(done_out), .wr_en_out(wr_en_out), .wr_r1r0_out(wr_r1r0_out), .pc_out(pc_out),
	.sreg_out(sreg_out));

// ---- cab_rf_model.sv ----
// register file model on the far side of the unit
// assumes writes land on the edge after done
`timescale 1ns/100ps
module cab_rf_model (
	input wire logic clk_in, // clock
	input wire logic [4:0] dst_in, // Rd index
	input wire logic wr_en_in, // write
	input wire logic wr_pair_in, // pair write
	input wire logic wr_r1r0_in, // pair is R1:R0
	input wire logic [15:0] res_in, // result
	output logic [7:0] rd_out, // Rd value
	output logic [15:0] r1r0_out // R1:R0 value
);
	logic [7:0] rf [32];
	wire [4:0] base = wr_r1r0_in ? 5'h0 : dst_in;
	assign rd_out = rf[dst_in];
	assign r1r0_out = {rf[1], rf[0]};
	initial foreach (rf[i]) rf[i] = 8'h00;
	// writeback, high byte one above
	always @(posedge clk_in)
	begin
		if (wr_en_in === 1'b1)
		begin
			rf[base] <= res_in[7:0];
			if (wr_pair_in === 1'b1)
				rf[base + 5'h1] <= res_in[15:8];
		end
	end
endmodule

// ---- cab_alu_branch_unit_bench.sv ----
// self-checking bench for the execution unit
// assumes the register file model and the bound checker
`timescale 1ns/100ps
module cab_alu_branch_unit_bench;
	logic clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic issue = 1'b0, two = 1'b0, use_rf = 1'b0, wr = 1'b0, rd = 1'b0;
	cab_pkg::cab_op_t op = cab_pkg::OP_NONE;
	logic [7:0] d = 8'h00, r = 8'h00, imm = 8'h00, io = 8'h00, addr = 8'h00;
	logic [15:0] pair = 16'h0000;
	logic [11:0] ofs = 12'h000;
	logic [31:0] wdata = 32'h0000_0000, rdata;
	logic busy, done, wen, wpair, w10;
	logic [15:0] res, r10;
	logic [21:0] pc;
	logic [7:0] sreg, rf_d;
	int errors = 0, total_checks = 0, n;
	always #4 clk_in = ~clk_in;
	cab_alu_branch_unit i_cab_alu_branch_unit (.clk_in(clk_in), .rstn_in(rstn_in),
		.issue_in(issue), .op_in(op), .opd_d_in(use_rf ? rf_d : d), .opd_r_in(r),
		.imm_in(imm), .pair_in(pair), .offset_in(ofs), .io_val_in(io), .next_two_word_in(two),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_rdata_out(rdata), .busy_out(busy), .done_out(done), .wr_en_out(wen),
		.wr_pair_out(wpair), .wr_r1r0_out(w10), .result_out(res), .pc_out(pc), .sreg_out(sreg));
	cab_rf_model i_cab_rf_model (.clk_in(clk_in), .dst_in(5'h10), .wr_en_in(wen),
		.wr_pair_in(wpair), .wr_r1r0_in(w10), .res_in(res), .rd_out(rf_d), .r1r0_out(r10));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict;
		if (errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// one operation: wait for done, check cost and pc
	task automatic run(input cab_pkg::cab_op_t o, input int cyc, input logic [21:0] x);
		@(posedge clk_in);
		issue <= 1'b1;
		op <= o;
		@(posedge clk_in);
		issue <= 1'b0;
		n = 1;
		#1;
		while (done !== 1'b1 && n < 6)
		begin
			@(posedge clk_in);
			#1;
			n++;
		end
		chk(n, cyc);
		chk({10'h000, pc}, {10'h000, x});
		@(posedge clk_in);
	endtask
	task automatic reg_io(input logic w, input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_in);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= v;
		@(posedge clk_in);
		wr <= 1'b0;
		rd <= 1'b0;
		#1;
		if (!w)
			chk(rdata, v);
		@(posedge clk_in);
	endtask
	// branches over all flag tests, tk bit set where taken
	task automatic t_branch(input logic [7:0] s, input logic [17:0] tk);
		reg_io(1'b1, 8'h00, {24'h0, s});
		imm <= 8'h03;
		ofs <= 12'h005;
		for (int i = 0; i < 18; i++)
			run(cab_pkg::cab_op_t'(cab_pkg::OP_BRANCH_FLAG_SET + i), tk[i] ? 2 : 1,
				pc + (tk[i] ? 22'h6 : 22'h1));
		chk(sreg, s);
	endtask
	initial
	begin
		#100000;
		errors++;
		give_verdict;
	end
	// main sequence
	initial
	begin
		repeat (4) @(posedge clk_in);
		rstn_in <= 1'b1;
		reg_io(1'b0, 8'h04, 32'h0);
		reg_io(1'b0, 8'h0c, 32'h0);
		use_rf <= 1'b1;
		r <= 8'h7f;
		run(cab_pkg::OP_SUM, 1, pc + 22'h1);
		r <= 8'h01;
		run(cab_pkg::OP_SUM, 1, pc + 22'h1);
		chk(sreg, 8'h2c);
		@(posedge clk_in);
		#1;
		chk(rf_d, 8'h80);
		use_rf <= 1'b0;
		run(cab_pkg::OP_DIFFERENCE_BORROW_IN, 1, pc + 22'h1);
		chk({sreg, res[7:0]}, 16'h35ff);
		pair <= 16'hffff;
		imm <= 8'h01;
		run(cab_pkg::OP_WORD_IMMEDIATE_SUM, 2, pc + 22'h1);
		chk({sreg, res}, 24'h23_0000);
		r <= 8'h80;
		run(cab_pkg::OP_OR, 1, pc + 22'h1);
		chk(sreg, 8'h35);
		d <= 8'h80;
		run(cab_pkg::OP_SIGNED_PRODUCT, 2, pc + 22'h1);
		chk({sreg[1:0], res}, 18'h0_4000);
		run(cab_pkg::OP_FRACTIONAL_SIGNED_PRODUCT, 2, pc + 22'h1);
		chk({sreg[1:0], res}, 18'h0_8000);
		d <= 8'hff;
		r <= 8'hff;
		run(cab_pkg::OP_UNSIGNED_PRODUCT, 2, pc + 22'h1);
		@(posedge clk_in);
		#1;
		chk({sreg[1:0], r10}, 18'h1_fe01);
		reg_io(1'b1, 8'h08, 32'h0);
		reg_io(1'b0, 8'h08, 32'h0000_fe01);
		d <= 8'h10;
		r <= 8'h20;
		run(cab_pkg::OP_COMPARE, 1, pc + 22'h1);
		chk({sreg, res}, 24'h15_0000);
		run(cab_pkg::OP_SELF_FLAG_CHECK, 1, pc + 22'h1);
		chk({sreg, res}, 24'h01_0000);
		run(cab_pkg::OP_CLEAR_MASK_BITS, 1, pc + 22'h1);
		chk({sreg, res}, 24'h01_0010);
		reg_io(1'b1, 8'h04, 32'h003f_0010);
		ofs <= 12'hffe;
		run(cab_pkg::OP_RELATIVE_JUMP, 2, 22'h3f_000f);
		pair <= 16'h1234;
		run(cab_pkg::OP_INDIRECT_JUMP, 2, 22'h00_1234);
		d <= 8'h5a;
		r <= 8'h5a;
		two <= 1'b1;
		run(cab_pkg::OP_EQUAL_SKIP_COMPARE, 3, pc + 22'h3);
		r <= 8'h08;
		two <= 1'b0;
		run(cab_pkg::OP_EQUAL_SKIP_COMPARE, 1, pc + 22'h1);
		io <= 8'h08;
		imm <= 8'h03;
		run(cab_pkg::OP_SKIP_IO_BIT_SET, 2, pc + 22'h2);
		d <= 8'h08;
		run(cab_pkg::OP_SKIP_REG_BIT_CLEAR, 1, pc + 22'h1);
		t_branch(8'hff, 18'h1_5565);
		t_branch(8'h08, 18'h1_aa99);
		give_verdict;
	end
endmodule
